// file: rtl/lmb_defines.svh
// Constants for the local multiplexed burst bus master
`ifndef LMB_DEFINES_SVH
`define LMB_DEFINES_SVH
`define LMB_REGION_8 2'h0
`define LMB_REGION_16 2'h1
`define LMB_REGION_32 2'h2
`define LMB_BE_IDLE 4'hf
`define LMB_AD_IDLE 32'h0000_0000
`define LMB_STEP_8 2'h1
`define LMB_STEP_16 2'h2
`endif

// file: rtl/lmb_pkg.sv
// Types for the local multiplexed burst bus master
package lmb_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_DATA, ST_RECOV, ST_HOLD, ST_HALT} lmb_state_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [1:0] count_m1;
    logic write;
    logic data_acc;
    logic [1:0] region;
    logic [3:0] be_n;
    logic [3:0][31:0] wdata;
  } lmb_req_t;

  typedef struct packed {
    logic [31:0] ad;
    logic ad_oe;
    logic ctl_oe;
    logic strobe_n;
    logic ale;
    logic last_n;
    logic [3:0] be_n;
    logic dphase_n;
    logic dir;
    logic dc;
    logic wr;
    logic grant;
  } lmb_pins_t;

  typedef struct packed {
    lmb_state_t st;
    lmb_pins_t pin;
    lmb_req_t req;
    logic [1:0] xfer;
    logic [1:0] low_a;
    logic last_wr;
    logic [31:0] last_addr;
    logic [31:0] last_data;
    logic [31:0] rdata;
    logic rvalid;
    logic done;
    logic strap_taken;
    logic core_hold;
    logic ready_s1;
    logic ready_s2;
    logic hold_s1;
    logic hold_s2;
    logic strap_s1;
    logic strap_s2;
  } lmb_regs_t;
endpackage : lmb_pkg

// file: rtl/lmb_bus_master.sv
// Local multiplexed burst bus master sequencer and pin driver
`timescale 1ns/1ps
`include "lmb_defines.svh"
module lmb_bus_master (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Core request side
  input wire logic req_valid,
  input wire lmb_pkg::lmb_req_t req,
  output logic req_ready,
  output logic [31:0] rd_data,
  output logic rd_valid,
  output logic xfer_done,
  // Core control
  input wire logic halt_req,
  input wire logic core_rst_clear,
  output logic core_in_reset,
  // Bus pins
  input wire logic [31:0] addr_data_bus_in,
  output logic [31:0] addr_data_bus_out,
  output logic addr_data_bus_oe,
  output logic ctl_oe,
  output logic addr_strobe_n,
  output logic addr_latch_en,
  output logic last_xfer_n,
  output logic [3:0] byte_lane_en_n,
  output logic data_phase_en_n,
  output logic xfer_dir,
  output logic data_code,
  output logic write_read,
  input wire logic ext_ready_recover_n,
  input wire logic hold_req,
  output logic bus_grant_ack,
  input wire logic rst_mode_strap
);
  import lmb_pkg::*;

  lmb_regs_t r;
  lmb_regs_t n;

  // ----------------------------------------
  // Byte lane mapping
  // ----------------------------------------
  function automatic logic [3:0] lane_map(input logic [1:0] region, input logic [3:0] be_n,
                                          input logic [1:0] low_a);
    logic [3:0] m;
    m = be_n;
    if (region == `LMB_REGION_16)
      m = {be_n[1], 1'b1, low_a[1], be_n[0]};
    else if (region == `LMB_REGION_8)
      m = {2'b11, low_a};
    return m;
  endfunction : lane_map

  function automatic logic strap_ok();
    return r.strap_taken && !r.core_hold;
  endfunction : strap_ok

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic rdy;
  logic hold_rq;
  assign rdy = ~r.ready_s2;
  assign hold_rq = r.hold_s2;

  always_comb
  begin
    n = r;
    n.rvalid = 1'b0;
    n.done = 1'b0;
    // Ready, hold and strap pins pass two flops before use; first stage read by second only
    n.ready_s1 = ext_ready_recover_n;
    n.ready_s2 = r.ready_s1;
    n.hold_s1 = hold_req;
    n.hold_s2 = r.hold_s1;
    n.strap_s1 = rst_mode_strap;
    n.strap_s2 = r.strap_s1;
    // Strap taken once, after reset release through the synchroniser
    if (!r.strap_taken)
    begin
      n.strap_taken = 1'b1;
      n.core_hold = ~r.strap_s2;
    end
    else if (core_rst_clear)
    begin
      n.core_hold = 1'b0;
    end
    unique case (r.st)
      ST_IDLE:
      begin
        if (hold_rq)
        begin
          n.st = ST_HOLD;
          n.pin.grant = 1'b1;
          n.pin.ctl_oe = 1'b0;
          n.pin.ad_oe = 1'b0;
        end
        else if (halt_req)
        begin
          n.st = ST_HALT;
          n.pin.ad_oe = 1'b1;
          n.pin.ad[31:2] = r.last_wr ? r.last_data[31:2] : r.last_addr[31:2];
          n.pin.ad[1:0] = r.req.count_m1;
          n.pin.ale = 1'b0;
          n.pin.dphase_n = 1'b1;
          n.pin.strobe_n = 1'b1;
          n.pin.last_n = 1'b1;
        end
        else if (req_valid && strap_ok())
        begin
          n.st = ST_ADDR;
          n.req = req;
          n.xfer = 2'h0;
          n.low_a = req.addr[1:0];
          n.pin.ad_oe = 1'b1;
          n.pin.ad = {req.addr[31:2], req.count_m1};
          n.pin.strobe_n = 1'b0;
          n.pin.ale = 1'b1;
          n.pin.be_n = lane_map(req.region, req.be_n, req.addr[1:0]);
          n.pin.dir = req.write;
          n.pin.wr = req.write;
          n.pin.dc = req.data_acc;
          n.last_wr = req.write;
          n.last_addr = req.addr;
        end
      end
      ST_ADDR:
      begin
        n.st = ST_DATA;
        n.pin.strobe_n = 1'b1;
        n.pin.ale = 1'b0;
        n.pin.dphase_n = 1'b0;
        n.pin.last_n = (r.req.count_m1 != 2'h0);
        n.pin.ad_oe = r.req.write;
        n.pin.ad = r.req.wdata[0];
        if (r.req.write)
          n.last_data = r.req.wdata[0];
      end
      ST_DATA:
      begin
        if (rdy)
        begin
          n.rvalid = ~r.req.write;
          n.rdata = addr_data_bus_in;
          if (r.xfer == r.req.count_m1)
          begin
            n.st = ST_RECOV;
            n.done = 1'b1;
            n.pin.dphase_n = 1'b1;
            n.pin.last_n = 1'b1;
            n.pin.ad_oe = 1'b0;
            n.pin.be_n = `LMB_BE_IDLE;
          end
          else
          begin
            n.xfer = 2'(r.xfer + 2'h1);
            n.pin.last_n = (n.xfer != r.req.count_m1);
            n.pin.ad = r.req.wdata[n.xfer];
            if (r.req.write)
              n.last_data = r.req.wdata[n.xfer];
            if (r.req.region == `LMB_REGION_8)
              n.low_a = 2'(r.low_a + `LMB_STEP_8);
            else if (r.req.region == `LMB_REGION_16)
              n.low_a = 2'(r.low_a + `LMB_STEP_16);
            n.pin.be_n = lane_map(r.req.region, r.req.be_n, n.low_a);
          end
        end
        // Without ready every bus pin holds, rd_valid and xfer_done stay low: a wait state
      end
      ST_RECOV:
      begin
        // Direction kept here; data-phase enable already released
        if (~rdy)
          n.st = ST_IDLE;
      end
      ST_HOLD:
      begin
        if (!hold_rq)
        begin
          n.st = ST_IDLE;
          n.pin.grant = 1'b0;
          n.pin.ctl_oe = 1'b1;
        end
      end
      ST_HALT:
      begin
        if (hold_rq)
        begin
          n.st = ST_HOLD;
          n.pin.grant = 1'b1;
          n.pin.ctl_oe = 1'b0;
          n.pin.ad_oe = 1'b0;
        end
        else if (!halt_req)
        begin
          n.st = ST_IDLE;
          n.pin.ad_oe = 1'b0;
        end
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      r <= '0;
      r.st <= ST_IDLE;
      r.pin.ad <= `LMB_AD_IDLE;
      r.pin.ctl_oe <= 1'b1;
      r.pin.strobe_n <= 1'b1;
      r.pin.last_n <= 1'b1;
      r.pin.be_n <= `LMB_BE_IDLE;
      r.pin.dphase_n <= 1'b1;
      r.pin.dir <= 1'b0;
      r.pin.ale <= 1'b0;
      r.core_hold <= 1'b1;
      r.ready_s1 <= 1'b1;
      r.ready_s2 <= 1'b1;
      // Strap keeps shifting in reset so its level is known at release
      r.strap_s1 <= rst_mode_strap;
      r.strap_s2 <= r.strap_s1;
    end
    else if (clk_en)
    begin
      r <= n;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign req_ready = (r.st == ST_IDLE) && !hold_rq && !halt_req && strap_ok();
  assign rd_data = r.rdata;
  assign rd_valid = r.rvalid;
  assign xfer_done = r.done;
  assign core_in_reset = r.core_hold;
  assign addr_data_bus_out = r.pin.ad;
  assign addr_data_bus_oe = r.pin.ad_oe;
  assign ctl_oe = r.pin.ctl_oe;
  assign addr_strobe_n = r.pin.strobe_n;
  assign addr_latch_en = r.pin.ale;
  assign last_xfer_n = r.pin.last_n;
  assign byte_lane_en_n = r.pin.be_n;
  assign data_phase_en_n = r.pin.dphase_n;
  // Direction only changes on address entry, never in a data phase
  assign xfer_dir = r.pin.dir;
  assign data_code = r.pin.dc;
  assign write_read = r.pin.wr;
  assign bus_grant_ack = r.pin.grant;
endmodule : lmb_bus_master

// file: tb/lmb_bus_master_sva.sv
// Pin-level assertions for the bus master
`timescale 1ns/1ps
module lmb_bus_master_sva (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Bus pins
  input wire logic addr_data_bus_oe,
  input wire logic ctl_oe,
  input wire logic addr_strobe_n,
  input wire logic addr_latch_en,
  input wire logic last_xfer_n,
  input wire logic [3:0] byte_lane_en_n,
  input wire logic data_phase_en_n,
  input wire logic xfer_dir,
  input wire logic data_code,
  input wire logic write_read,
  input wire logic bus_grant_ack
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // ----------------
  // Assertions
  // ----------------
  sequence two_data;
    !data_phase_en_n ##1 !data_phase_en_n;
  endsequence
  strobe_latch_a: assert property (!addr_strobe_n |-> addr_latch_en && addr_data_bus_oe)
    else $error("strobe without latch");
  one_addr_a: assert property (!addr_strobe_n |=> addr_strobe_n && !addr_latch_en
    && !data_phase_en_n) else $error("no data state after address");
  dir_match_a: assert property (!addr_strobe_n |-> xfer_dir == write_read)
    else $error("direction wrong");
  dir_steady_a: assert property (two_data |-> $stable(xfer_dir))
    else $error("direction moved in data");
  qual_hold_a: assert property (two_data |-> $stable({write_read, data_code,
    byte_lane_en_n[3:2]})) else $error("qualifier moved in data");
  last_data_a: assert property (!last_xfer_n |-> !data_phase_en_n)
    else $error("last marker outside data");
  grant_float_a: assert property (bus_grant_ack |-> !ctl_oe && !addr_data_bus_oe)
    else $error("bus driven in grant");
  reset_pins_a: assert property ($fell(sys_rst) |-> addr_strobe_n && !addr_latch_en
    && !xfer_dir && data_phase_en_n) else $error("reset pin levels");
endmodule : lmb_bus_master_sva

bind lmb_bus_master lmb_bus_master_sva chk (.core_clk, .sys_rst, .addr_data_bus_oe, .ctl_oe,
  .addr_strobe_n, .addr_latch_en, .last_xfer_n, .byte_lane_en_n, .data_phase_en_n, .xfer_dir,
  .data_code, .write_read, .bus_grant_ack);

// file: tb/lmb_mem_model.sv
// Far-side memory and ready logic model
`timescale 1ns/1ps
module lmb_mem_model (
  // Clock
  input wire logic core_clk,
  // Master pins
  input wire logic addr_strobe_n,
  input wire logic data_phase_en_n,
  input wire logic xfer_dir,
  // Wait states per transfer
  input wire logic [3:0] waits,
  // Answer
  output logic ext_ready_recover_n = 1'h1,
  output logic [31:0] mem_data
);
  logic [3:0] cnt_r = 4'h0;
  logic [31:0] word_r = 32'h0000_0000;
  // Released bus shows the inverse, not a stale word
  assign mem_data = (!data_phase_en_n && !xfer_dir) ? word_r : ~word_r;
  // Gap of four covers the master's ready synchroniser
  always @(posedge core_clk)
  begin
    ext_ready_recover_n <= 1'h1;
    cnt_r <= cnt_r + 4'h1;
    if (!addr_strobe_n) word_r <= 32'h5a5a_0000;
    if (data_phase_en_n) cnt_r <= 4'h0;
    else if (cnt_r == waits) ext_ready_recover_n <= 1'h0;
    else if (cnt_r == waits + 4'h4)
    begin
      cnt_r <= 4'h0;
      word_r <= word_r + 32'h0000_0001;
    end
  end
endmodule : lmb_mem_model

// file: tb/test_lmb_bus_master.sv
// Self-checking bench for the bus master
`timescale 1ns/1ps
`include "lmb_defines.svh"
module test_lmb_bus_master;
  import lmb_pkg::*;
  typedef struct packed {logic wr; logic [1:0] cnt; logic dc; logic [1:0] rg; logic [3:0] wt;
    logic hlt; logic [31:0] a;} lmb_row_t;
  logic core_clk = 0, sys_rst = 1, clk_en = 1, req_valid = 0, halt_req = 0, core_rst_clear = 0;
  logic hold_req = 0, rst_mode_strap = 0, req_ready, rd_valid, xfer_done, core_in_reset;
  logic addr_data_bus_oe, ctl_oe, addr_strobe_n, addr_latch_en, last_xfer_n, data_phase_en_n;
  logic xfer_dir, data_code, write_read, ext_ready_recover_n, bus_grant_ack;
  logic [31:0] rd_data, addr_data_bus_in, addr_data_bus_out, mem_data;
  logic [3:0] byte_lane_en_n, waits = 0;
  lmb_req_t req = '0;
  int n_errors = 0, checked = 0;
  lmb_row_t rows [5] = '{
    '{1'h1, 2'h0, 1'h1, `LMB_REGION_32, 4'h0, 1'h0, 32'h0000_1000},
    '{1'h0, 2'h1, 1'h1, `LMB_REGION_16, 4'h2, 1'h0, 32'h0000_2002},
    '{1'h0, 2'h2, 1'h0, `LMB_REGION_8, 4'h0, 1'h0, 32'h0000_3001},
    '{1'h1, 2'h3, 1'h1, `LMB_REGION_32, 4'h1, 1'h1, 32'h0000_4000},
    '{1'h0, 2'h3, 1'h0, `LMB_REGION_32, 4'h0, 1'h1, 32'h0000_5000}};
  lmb_bus_master uut (.*);
  lmb_mem_model far_end (.*);
  assign addr_data_bus_in = addr_data_bus_oe ? addr_data_bus_out : mem_data;
  always #4 core_clk = ~core_clk;
  // ----------------
  // Tasks
  // ----------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : cmp
  task automatic run(input lmb_row_t r);
    int t = 0;
    int n = 0;
    logic [31:0] lw;
    logic [3:0] eb;
    req = '{r.a, r.cnt, r.wr, r.dc, r.rg, 4'h2, {32'hc3c3_0003, 32'hc3c3_0002, 32'hc3c3_0001,
      32'hc3c3_0000}};
    waits = r.wt;
    req_valid = 1'h1;
    while (!req_ready && t < 50)
    begin
      @(negedge core_clk);
      t++;
    end
    cmp(req_ready, 1'h1, "ready");
    @(negedge core_clk);
    req_valid = 1'h0;
    while (addr_strobe_n && t < 60)
    begin
      @(negedge core_clk);
      t++;
    end
    eb = r.rg == `LMB_REGION_32 ? 4'h2 : r.rg == `LMB_REGION_16 ? {2'h3, r.a[1], 1'h0} :
      {2'h3, r.a[1:0]};
    cmp(addr_data_bus_out, {r.a[31:2], r.cnt}, "addr");
    cmp(byte_lane_en_n, eb, "lanes");
    cmp({write_read, data_code, xfer_dir}, {r.wr, r.dc, r.wr}, "qual");
    @(negedge core_clk);
    if (r.wr) cmp(addr_data_bus_out, 32'hc3c3_0000, "wdata");
    while (!xfer_done && t < 200)
    begin
      @(negedge core_clk);
      t++;
      if (rd_valid)
      begin
        cmp(rd_data, 32'h5a5a_0000 + n, "rdata");
        n++;
      end
      if (!last_xfer_n && r.rg == `LMB_REGION_8)
        cmp(byte_lane_en_n[1:0], 2'(r.a[1:0] + r.cnt), "a10");
    end
    cmp(xfer_done, 1'h1, "done");
    if (!r.wr) cmp(n, r.cnt + 1, "words");
    if (r.hlt)
    begin
      halt_req = 1'h1;
      repeat (8) @(negedge core_clk);
      lw = r.wr ? 32'hc3c3_0000 + r.cnt : r.a;
      cmp(addr_data_bus_out, {lw[31:2], r.cnt}, "halt");
      cmp(data_phase_en_n, 1'h1, "halt den");
      halt_req = 1'h0;
      repeat (4) @(negedge core_clk);
    end
    $display("row done at %0t", $time);
  endtask : run
  task automatic final_report;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report
  // ----------------
  // Sequence
  // ----------------
  initial
  begin
    repeat (6) @(negedge core_clk);
    cmp({xfer_dir, addr_strobe_n}, 2'h1, "reset");
    sys_rst = 1'h0;
    repeat (4) @(negedge core_clk);
    cmp(core_in_reset, 1'h1, "strap");
    core_rst_clear = 1'h1;
    @(negedge core_clk);
    core_rst_clear = 1'h0;
    $display("reset done at %0t", $time);
    foreach (rows[i]) run(rows[i]);
    // Enable low: hold request must not even reach the synchroniser
    clk_en = 1'h0;
    hold_req = 1'h1;
    repeat (5) @(negedge core_clk);
    cmp(bus_grant_ack, 1'h0, "frozen");
    clk_en = 1'h1;
    repeat (5) @(negedge core_clk);
    cmp({bus_grant_ack, ctl_oe, req_ready}, 3'h4, "grant");
    hold_req = 1'h0;
    repeat (5) @(negedge core_clk);
    cmp({bus_grant_ack, ctl_oe}, 2'h1, "resume");
    $display("hold done at %0t", $time);
    // Second reset with the strap high: core runs at once
    rst_mode_strap = 1'h1;
    sys_rst = 1'h1;
    repeat (6) @(negedge core_clk);
    cmp({xfer_dir, addr_strobe_n, bus_grant_ack}, 3'h2, "reset again");
    sys_rst = 1'h0;
    repeat (2) @(negedge core_clk);
    cmp(core_in_reset, 1'h0, "strap high");
    run(rows[0]);
    $display("second reset done at %0t", $time);
    final_report();
  end
  // Whole run needs well under 2000 cycles
  initial
  begin
    #20000;
    n_errors++;
    final_report();
  end
endmodule : test_lmb_bus_master
